// ---- core/dasf_alu.sv ----
// byte alu with flag generation for the data address and flag core
`timescale 1ns/100ps
`default_nettype none
module dasf_alu (
  // operation select
  input  wire dasf_pkg::dasf_op_t op,
  input  wire logic [2:0]         bit_sel,
  input  wire logic               c_in,
  // operands: a is the file or literal, b the accumulator
  input  wire logic [7:0]         a,
  input  wire logic [7:0]         b,
  // results
  output logic      [7:0]         result,
  output logic      [4:0]         flags,
  output logic      [4:0]         mask
);

  logic [8:0] sum9;
  logic [4:0] half;
  logic [7:0] nb;
  logic       ov;
  logic       c;
  logic       dc;

  // one case per opcode; subtract adds the two's complement of b
  always_comb
  begin
    sum9   = 9'h000;
    half   = 5'h00;
    nb     = ~b;
    ov     = 1'b0;
    c      = 1'b0;
    dc     = 1'b0;
    result = a;
    mask   = dasf_pkg::MASK_NONE;
    unique case (op)
      dasf_pkg::OP_ADD:
      begin
        sum9   = {1'b0, a} + {1'b0, b};
        half   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        result = sum9[7:0];
        c      = sum9[8];
        dc     = half[4];
        ov     = (a[7] == b[7]) && (result[7] != a[7]);
        mask   = dasf_pkg::MASK_ALL;
      end
      dasf_pkg::OP_SUB:
      begin
        // carry out of a + ~b + 1 is the inverted borrow
        sum9   = {1'b0, a} + {1'b0, nb} + 9'h001;
        half   = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + 5'h01;
        result = sum9[7:0];
        c      = sum9[8];
        dc     = half[4];
        ov     = (a[7] != b[7]) && (result[7] != a[7]);
        mask   = dasf_pkg::MASK_ALL;
      end
      dasf_pkg::OP_AND:
      begin
        result = a & b;
        mask   = dasf_pkg::MASK_NZ;
      end
      dasf_pkg::OP_OR:
      begin
        result = a | b;
        mask   = dasf_pkg::MASK_NZ;
      end
      dasf_pkg::OP_XOR:
      begin
        result = a ^ b;
        mask   = dasf_pkg::MASK_NZ;
      end
      dasf_pkg::OP_RRF:
      begin
        result = {c_in, a[7:1]};
        c      = a[0];
        dc     = a[4]; // bit 4 moves down into the low nibble
        mask   = dasf_pkg::MASK_ROT;
      end
      dasf_pkg::OP_RLF:
      begin
        result = {a[6:0], c_in};
        c      = a[7];
        dc     = a[3]; // bit 3 moves up into the high nibble
        mask   = dasf_pkg::MASK_ROT;
      end
      dasf_pkg::OP_CLR:
      begin
        result = 8'h00;
        mask   = dasf_pkg::MASK_Z;
      end
      dasf_pkg::OP_MOVF: result = a;
      dasf_pkg::OP_MOVW: result = b;
      dasf_pkg::OP_BCLR: result = a & ~(8'h01 << bit_sel);
      dasf_pkg::OP_BSET: result = a | (8'h01 << bit_sel);
      dasf_pkg::OP_SWAP: result = {a[3:0], a[7:4]};
    endcase
    flags              = 5'h00;
    flags[dasf_pkg::FLG_N]  = result[7];
    flags[dasf_pkg::FLG_OV] = ov;
    flags[dasf_pkg::FLG_Z]  = (result == 8'h00);
    flags[dasf_pkg::FLG_DC] = dc;
    flags[dasf_pkg::FLG_C]  = c;
  end

endmodule : dasf_alu
`default_nettype wire

// ---- core/dasf_core.sv ----
// data address resolution, pointer pairs and flag register with apb access
// Functional notes
// - flag register as target: flags win for flag-updating ops, neutral ops store result bits 4-0
// - clearing flag register sets only zero flag
// - flag bits 7-5 read zero, five bits rw
// - negative flag copies result bit 7
// - signed wrap flag on sign-changing magnitude overflow
// - zero flag set when result equals zero
// - nibble carry from bit 3, inverted for subtract
// - carry from bit 7, inverted borrow on subtract
// - subtract adds two's complement of second operand
// - rotates load nibble carry from bit 4/3
// - rotates load carry from outgoing end bit
// - access bit one: bank select forms address
// - access bit zero: access bank, bank ignored
// - full 12-bit address used directly, bank ignored
// - destination bit picks source file or accumulator
// - call and jump carry 20-bit program address
// - three 12-bit pointer pairs, high nibble unused
// - virtual operand accesses memory at its pointer
// - indirect target ignores bank and access bit
// - indexed literal offset only with extended set
// - operands for plain, increment, decrement, offset access
// - post operands access first, then step pointer
// - offset operand uses pointer plus signed accumulator
// - pointer steps carry across the whole pair
// - pointer steps leave every flag untouched
`timescale 1ns/100ps
`default_nettype none
module dasf_core (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // execute request from the instruction decoder
  input  wire logic                exec_valid,
  input  wire dasf_pkg::dasf_op_t  exec_op,
  input  wire dasf_pkg::dasf_mode_t exec_mode,
  input  wire logic [7:0]          exec_operand,
  input  wire logic [7:0]          exec_file,
  input  wire logic                exec_access,
  input  wire logic                exec_dest,
  input  wire logic [2:0]          exec_bit,
  input  wire logic [11:0]         exec_full_addr,
  input  wire logic [19:0]         exec_prog_addr,
  // data memory side
  output logic                     mem_valid,
  output logic      [11:0]         mem_addr,
  output logic                     mem_write,
  output logic      [7:0]          mem_wdata,
  // program flow
  output logic                     jump_valid,
  output logic      [19:0]         jump_target,
  // visible state
  output logic      [7:0]          flag_out,
  output logic      [7:0]          acc_out
);

  logic [3:0]  bank_select_reg;
  logic [11:0] ptr [3];
  logic        extended_set_config_bit;
  logic        apb_wr;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [11:0] direct_addr;
  logic [11:0] target;
  logic [11:0] ptr_cur;
  logic [11:0] ptr_next;
  logic [11:0] diff;
  logic        virt_hit;
  logic [1:0]  virt_idx;
  logic [2:0]  virt_kind;
  logic        has_addr;
  logic        file_wr;
  logic        acc_wr;
  logic        is_flag;
  logic        ptr_step;
  logic        ilo;
  logic [7:0]  alu_res;
  logic [4:0]  alu_flags;
  logic [4:0]  alu_mask;

  // twelve-bit wrapping add shared by every pointer path
  function automatic logic [11:0] ptr_add(input logic [11:0] p,
                                          input logic [11:0] d);
    ptr_add = p + d;
  endfunction : ptr_add

  // access bank: low half in bank zero, high half in the top bank
  function automatic logic [11:0] access_map(input logic [7:0] f);
    access_map = (f < dasf_pkg::ACC_SPLIT) ? {dasf_pkg::ACC_LO_BANK, f}
                                          : {dasf_pkg::ACC_HI_BANK, f};
  endfunction : access_map

  dasf_alu u_alu (
    .op      (exec_op),
    .bit_sel (exec_bit),
    .c_in    (flag_out[dasf_pkg::FLG_C]),
    .a       (exec_operand),
    .b       (acc_out),
    .result  (alu_res),
    .flags   (alu_flags),
    .mask    (alu_mask)
  );

  // direct address before any virtual operand is recognised
  always_comb
  begin
    ilo         = 1'b0;
    direct_addr = exec_full_addr;
    if (exec_mode == dasf_pkg::M_DIR)
    begin
      if (exec_access)
        direct_addr = {bank_select_reg, exec_file};
      else if (extended_set_config_bit && exec_file <= dasf_pkg::ILO_LIMIT)
      begin
        ilo         = 1'b1;
        direct_addr = ptr_add(ptr[2], {4'h0, exec_file});
      end
      else
        direct_addr = access_map(exec_file);
    end
  end

  // virtual operand decode; an indexed window result is never remapped
  always_comb
  begin
    virt_hit  = 1'b0;
    virt_idx  = 2'h0;
    virt_kind = dasf_pkg::V_PLAIN;
    diff      = 12'h000;
    for (int i = 0; i < 3; i++)
    begin
      if (!ilo && direct_addr <= dasf_pkg::VIRT_BASE[i] &&
          (dasf_pkg::VIRT_BASE[i] - direct_addr) <= dasf_pkg::VIRT_SPAN)
      begin
        diff      = dasf_pkg::VIRT_BASE[i] - direct_addr;
        virt_hit  = 1'b1;
        virt_idx  = 2'(i);
        virt_kind = diff[2:0];
      end
    end
  end

  // indirect target uses the pointer (plus accumulator for offset), never bank or access bit
  always_comb
  begin
    ptr_cur  = ptr[virt_idx];
    ptr_next = ptr_cur;
    ptr_step = 1'b0;
    target   = direct_addr;
    if (virt_hit)
    begin
      target = ptr_cur;
      unique case (virt_kind)
        dasf_pkg::V_DEREF_THEN_INCREMENT:
        begin
          ptr_next = ptr_add(ptr_cur, dasf_pkg::PTR_ONE);
          ptr_step = 1'b1;
        end
        dasf_pkg::V_DEREF_THEN_DECREMENT:
        begin
          ptr_next = ptr_add(ptr_cur, ~dasf_pkg::PTR_ONE + 12'h001);
          ptr_step = 1'b1;
        end
        dasf_pkg::V_PREINC:
        begin
          ptr_next = ptr_add(ptr_cur, dasf_pkg::PTR_ONE);
          target   = ptr_next;
          ptr_step = 1'b1;
        end
        dasf_pkg::V_DEREF_WITH_OFFSET:
          target = ptr_add(ptr_cur, {{4{acc_out[7]}}, acc_out});
        default: target = ptr_cur;
      endcase
    end
  end

  // where the result goes
  assign has_addr = (exec_mode == dasf_pkg::M_DIR) ||
                    (exec_mode == dasf_pkg::M_FULL);
  assign is_flag  = has_addr && (target == dasf_pkg::FLAG_SFR_ADDR);
  assign file_wr  = has_addr && exec_dest;
  assign acc_wr   = has_addr ? !exec_dest
                             : (exec_mode == dasf_pkg::M_INH ||
                                exec_mode == dasf_pkg::M_LIT);

  // flag register; hardware updates win over a same-cycle apb write
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      flag_out <= dasf_pkg::FLAG_RST;
    else if (exec_valid && exec_mode != dasf_pkg::M_JMP)
    begin
      if (file_wr && is_flag && alu_mask == dasf_pkg::MASK_NONE)
        flag_out[4:0] <= alu_res[4:0]; // neutral ops store as data
      else
        flag_out[4:0] <= (flag_out[4:0] & ~alu_mask) |
                         (alu_flags & alu_mask);
    end
    else if (apb_wr && paddr == dasf_pkg::REG_FLAG)
      flag_out[4:0] <= pwdata[4:0];
  end

  // accumulator
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      acc_out <= dasf_pkg::ACC_RST;
    else if (exec_valid && acc_wr)
      acc_out <= alu_res;
    else if (apb_wr && paddr == dasf_pkg::REG_ACC)
      acc_out <= pwdata[7:0];
  end

  // pointer pairs; a step wraps the full 12 bits, carrying into the high
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 3; i++)
        ptr[i] <= dasf_pkg::PTR_RST;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (exec_valid && has_addr && ptr_step && virt_idx == 2'(i))
          ptr[i] <= ptr_next;
        else if (apb_wr && paddr == dasf_pkg::REG_PTR0 + 8'(4 * i))
          ptr[i] <= pwdata[11:0];
      end
    end
  end

  // bank select and configuration, software only
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bank_select_reg         <= dasf_pkg::BANK_RST;
      extended_set_config_bit <= 1'b0;
    end
    else if (apb_wr && paddr == dasf_pkg::REG_BANK)
      bank_select_reg <= pwdata[3:0];
    else if (apb_wr && paddr == dasf_pkg::REG_CFG)
      extended_set_config_bit <= pwdata[0];
  end

  // memory request, one cycle after the execute pulse
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_valid <= 1'b0;
      mem_addr  <= 12'h000;
      mem_write <= 1'b0;
      mem_wdata <= 8'h00;
    end
    else
    begin
      mem_valid <= exec_valid && has_addr;
      mem_write <= exec_valid && file_wr && !is_flag;
      if (exec_valid)
      begin
        mem_wdata <= alu_res;
        if (has_addr)
          mem_addr <= target;
      end
    end
  end

  // program address for literal call and jump
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      jump_valid  <= 1'b0;
      jump_target <= 20'h00000;
    end
    else
    begin
      jump_valid <= exec_valid && exec_mode == dasf_pkg::M_JMP;
      if (exec_valid && exec_mode == dasf_pkg::M_JMP)
        jump_target <= exec_prog_addr;
    end
  end

  // apb read mux; unmapped offsets answer with an error and zero data
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      dasf_pkg::REG_FLAG: rd_mux = {24'h0, flag_out};
      dasf_pkg::REG_ACC:  rd_mux = {24'h0, acc_out};
      dasf_pkg::REG_BANK: rd_mux = {28'h0, bank_select_reg};
      dasf_pkg::REG_PTR0: rd_mux = {20'h0, ptr[0]};
      dasf_pkg::REG_PTR1: rd_mux = {20'h0, ptr[1]};
      dasf_pkg::REG_PTR2: rd_mux = {20'h0, ptr[2]};
      dasf_pkg::REG_CFG:  rd_mux = {31'h0, extended_set_config_bit};
      dasf_pkg::REG_LAST: rd_mux = {20'h0, mem_addr};
      default:            mapped = 1'b0;
    endcase
  end

  // one wait-free access cycle: data sampled in setup, ready in access
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (psel && !penable && !pready)
    begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  assign apb_wr = psel && penable && pready && pwrite && !pslverr;

  // checks on the flag, address and pointer behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_flag_upper_zero: assert property (
    flag_out[7:5] == 3'b000) else $error("flag upper bits not zero");
  a_flag_dest_drop: assert property (
    exec_valid && file_wr && is_flag && alu_mask != 5'h00
    |=> !mem_write ##0 mem_valid) else $error("flag target written");
  a_clr_flag_only_z: assert property (
    exec_valid && exec_op == dasf_pkg::OP_CLR && has_addr
    |=> flag_out == {3'b000, $past(flag_out[4:3]), 1'b1,
                     $past(flag_out[1:0])}) else $error("clear flags bad");
  a_add_flags: assert property (
    exec_valid && exec_op == dasf_pkg::OP_ADD
    |=> flag_out[4] == mem_wdata[7] &&
        flag_out[3] == ($past(exec_operand[7]) == $past(acc_out[7]) &&
                        mem_wdata[7] != $past(exec_operand[7])) &&
        flag_out[1] == ({1'b0, $past(exec_operand[3:0])} +
                        {1'b0, $past(acc_out[3:0])} > 5'h0f) &&
        flag_out[0] == ({1'b0, $past(exec_operand)} +
                        {1'b0, $past(acc_out)} > 9'h0ff))
    else $error("add flags wrong");
  a_sub_borrow: assert property (
    exec_valid && exec_op == dasf_pkg::OP_SUB
    |=> flag_out[0] == ($past(exec_operand) >= $past(acc_out)) &&
        mem_wdata == 8'($past(exec_operand) - $past(acc_out)))
    else $error("subtract borrow wrong");
  a_zero_flag: assert property (
    exec_valid && exec_op inside {dasf_pkg::OP_AND, dasf_pkg::OP_XOR}
    |=> flag_out[2] == (mem_wdata == 8'h00)) else $error("zero flag");
  a_rot_right: assert property (
    exec_valid && exec_op == dasf_pkg::OP_RRF
    |=> flag_out[0] == $past(exec_operand[0]) &&
        flag_out[1] == $past(exec_operand[4])) else $error("rrf flags");
  a_rot_left: assert property (
    exec_valid && exec_op == dasf_pkg::OP_RLF
    |=> flag_out[0] == $past(exec_operand[7]) &&
        flag_out[1] == $past(exec_operand[3])) else $error("rlf flags");
  a_bank_direct: assert property (
    exec_valid && exec_mode == dasf_pkg::M_DIR && exec_access && !virt_hit
    |=> mem_addr == {$past(bank_select_reg), $past(exec_file)})
    else $error("banked address wrong");
  a_access_bank: assert property (
    exec_valid && exec_mode == dasf_pkg::M_DIR && !exec_access &&
    !extended_set_config_bit && !virt_hit
    |=> mem_addr == access_map($past(exec_file))) else $error("access");
  a_full_addr: assert property (
    exec_valid && exec_mode == dasf_pkg::M_FULL && !virt_hit
    |=> mem_addr == $past(exec_full_addr)) else $error("full address");
  a_dest_acc: assert property (
    exec_valid && has_addr && !exec_dest
    |=> !mem_write && acc_out == mem_wdata) else $error("dest select");
  a_jump_target: assert property (
    exec_valid && exec_mode == dasf_pkg::M_JMP
    |=> jump_valid && jump_target == $past(exec_prog_addr) && !mem_valid)
    else $error("jump target wrong");
  a_post_inc: assert property (
    exec_valid && has_addr && virt_hit && virt_kind == dasf_pkg::V_DEREF_THEN_INCREMENT
    |=> mem_addr == $past(ptr_cur) &&
        ptr[$past(virt_idx)] == $past(ptr_cur) + 12'h001)
    else $error("post increment wrong");
  a_plus_offset: assert property (
    exec_valid && has_addr && virt_hit && virt_kind == dasf_pkg::V_DEREF_WITH_OFFSET
    |=> mem_addr == $past(ptr_cur) + {{4{$past(acc_out[7])}},
                                      $past(acc_out)} &&
        ptr[$past(virt_idx)] == $past(ptr_cur)) else $error("offset access");
  a_ptr_no_flags: assert property (
    exec_valid && has_addr && ptr_step && !is_flag &&
    exec_op == dasf_pkg::OP_MOVF
    |=> $stable(flag_out)) else $error("pointer step moved flags");

  c_post_inc: cover property (exec_valid && has_addr && ptr_step);
  c_flag_clear: cover property (exec_valid && is_flag &&
                                exec_op == dasf_pkg::OP_CLR);
  c_indexed: cover property (exec_valid && ilo);
  c_apb_error: cover property (pready && pslverr);

endmodule : dasf_core
`default_nettype wire

// ---- shared/dasf_pkg.sv ----
// constants, register map and types for the data address and flag core
package dasf_pkg;

  // apb register byte offsets
  localparam logic [7:0] REG_FLAG  = 8'h00;
  localparam logic [7:0] REG_ACC   = 8'h04;
  localparam logic [7:0] REG_BANK  = 8'h08;
  localparam logic [7:0] REG_PTR0  = 8'h0c;
  localparam logic [7:0] REG_PTR1  = 8'h10;
  localparam logic [7:0] REG_PTR2  = 8'h14;
  localparam logic [7:0] REG_CFG   = 8'h18;
  localparam logic [7:0] REG_LAST  = 8'h1c;

  // flag bit positions inside arith_flag_register
  localparam int FLG_N  = 4;
  localparam int FLG_OV = 3;
  localparam int FLG_Z  = 2;
  localparam int FLG_DC = 1;
  localparam int FLG_C  = 0;
  localparam int FLG_W  = 5;

  // which flags an operation updates
  localparam logic [4:0] MASK_NONE = 5'h00;
  localparam logic [4:0] MASK_ALL  = 5'h1f;
  localparam logic [4:0] MASK_NZ   = 5'h14;
  localparam logic [4:0] MASK_ROT  = 5'h17;
  localparam logic [4:0] MASK_Z    = 5'h04;

  // reset values
  localparam logic [7:0]  FLAG_RST = 8'h00;
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [3:0]  BANK_RST = 4'h0;
  localparam logic [11:0] PTR_RST  = 12'h000;

  // data space layout
  localparam logic [11:0] FLAG_SFR_ADDR = 12'hfd8;
  localparam logic [7:0]  ACC_SPLIT     = 8'h80;
  localparam logic [3:0]  ACC_LO_BANK   = 4'h0;
  localparam logic [3:0]  ACC_HI_BANK   = 4'hf;
  localparam logic [7:0]  ILO_LIMIT     = 8'h5f;

  // virtual operand blocks, one per pointer pair; entry [0] is pair zero
  localparam logic [2:0][11:0] VIRT_BASE = {12'hfdf, 12'he7f ^ 12'h198,
                                           12'hfef};
  localparam logic [11:0] VIRT_SPAN  = 12'h004;
  // distance below the block base selects the operand kind
  localparam logic [2:0]  V_PLAIN    = 3'h0;
  localparam logic [2:0]  V_DEREF_THEN_INCREMENT  = 3'h1;
  localparam logic [2:0]  V_DEREF_THEN_DECREMENT  = 3'h2;
  localparam logic [2:0]  V_PREINC   = 3'h3;
  localparam logic [2:0]  V_DEREF_WITH_OFFSET    = 3'h4;
  localparam logic [11:0] PTR_ONE    = 12'h001;

  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_RRF, OP_RLF, OP_CLR,
    OP_MOVF, OP_MOVW, OP_BCLR, OP_BSET, OP_SWAP
  } dasf_op_t;

  typedef enum logic [2:0] {
    M_INH, M_LIT, M_DIR, M_FULL, M_JMP
  } dasf_mode_t;

endpackage : dasf_pkg

// ---- sim/data_address_and_status_flags_tb_top.sv ----
// self-checking bench for the data address and flag core
`timescale 1ns/100ps
`default_nettype none
module data_address_and_status_flags_tb_top;
  logic                  sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic                  exec_valid, exec_access, exec_dest, mem_valid;
  logic                  mem_write, jump_valid, sl, xs;
  logic [7:0]            paddr, exec_operand, exec_file, mem_wdata;
  logic [7:0]            flag_out, acc_out, acc;
  logic [31:0]           pwdata, prdata, rd;
  logic [2:0]            exec_bit;
  logic [11:0]           exec_full_addr, mem_addr;
  logic [11:0]           ptr [3];
  logic [19:0]           exec_prog_addr, jump_target;
  logic [4:0]            fl;
  logic [3:0]            bank;
  dasf_pkg::dasf_op_t    exec_op;
  dasf_pkg::dasf_mode_t  exec_mode;
  int                    n_errors, total_checks;

  dasf_core i_dut (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .exec_valid, .exec_op, .exec_mode, .exec_operand,
    .exec_file, .exec_access, .exec_dest, .exec_bit, .exec_full_addr,
    .exec_prog_addr, .mem_valid, .mem_addr, .mem_write, .mem_wdata,
    .jump_valid, .jump_target, .flag_out, .acc_out
  );

  // 10 mhz core clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("[FAIL] %0t: %s", $time, msg);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, ad, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    sl = pslverr;
    {psel, penable} <= 2'b00;
    if (n == 20)
    begin
      $display("[FAIL] %0t: apb answer missing", $time);
      n_errors++;
      end_of_test();
    end
  endtask : apb

  // one exec request; the model predicts flags, acc, pointers and access
  task automatic ex(input dasf_pkg::dasf_op_t op,
                    input dasf_pkg::dasf_mode_t md, input logic [7:0] a, f,
                    input logic ac, d, input logic [19:0] p);
    logic [8:0]  s;
    logic [7:0]  r, bb;
    logic [4:0]  m, nf;
    logic [11:0] ad, tg, b;
    logic        w, ft, mv, il;
    @(posedge sys_clk);
    exec_op <= op;
    exec_mode <= md;
    {exec_operand, exec_file, exec_bit} <= {a, f, f[2:0]};
    {exec_access, exec_dest, exec_prog_addr} <= {ac, d, p};
    exec_full_addr <= p[11:0];
    exec_valid <= 1'b1;
    @(posedge sys_clk);
    exec_valid <= 1'b0;
    // subtract is add of the complement plus one, so carries mean no borrow
    bb = (op == dasf_pkg::OP_SUB) ? ~acc : acc;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, op == dasf_pkg::OP_SUB};
    r = s[7:0];
    m = 5'h1f;
    nf = {1'b0, (a[7] == bb[7]) && (r[7] != a[7]), 1'b0,
          s[4] ^ a[4] ^ bb[4], s[8]};
    case (op)
      dasf_pkg::OP_AND: {r, m} = {a & acc, 5'h14};
      dasf_pkg::OP_OR:  {r, m} = {a | acc, 5'h14};
      dasf_pkg::OP_XOR: {r, m} = {a ^ acc, 5'h14};
      dasf_pkg::OP_RRF: {r, m, nf[1:0]} = {fl[0], a[7:1], 5'h17, a[4], a[0]};
      dasf_pkg::OP_RLF: {r, m, nf[1:0]} = {a[6:0], fl[0], 5'h17, a[3], a[7]};
      dasf_pkg::OP_CLR: {r, m} = 13'h0004;
      dasf_pkg::OP_MOVW: {r, m} = {acc, 5'h00};
      dasf_pkg::OP_BCLR: {r, m} = {a & ~(8'h01 << f[2:0]), 5'h00};
      dasf_pkg::OP_BSET: {r, m} = {a | (8'h01 << f[2:0]), 5'h00};
      dasf_pkg::OP_SWAP: {r, m} = {a[3:0], a[7:4], 5'h00};
      dasf_pkg::OP_ADD, dasf_pkg::OP_SUB: m = 5'h1f;
      default: {r, m} = {a, 5'h00};
    endcase
    nf[4] = r[7];
    nf[2] = (r == 8'h00);
    mv = (md == dasf_pkg::M_DIR) || (md == dasf_pkg::M_FULL);
    il = xs && md == dasf_pkg::M_DIR && !ac && f <= dasf_pkg::ILO_LIMIT;
    ad = (md == dasf_pkg::M_FULL) ? p[11:0] : ac ? {bank, f} :
         il ? ptr[2] + {4'h0, f} : {{4{f[7]}}, f};
    tg = ad;
    for (int k = 0; k < 3; k++)
    begin
      b = dasf_pkg::VIRT_BASE[k] - ad;
      if (mv && !il && b < 12'h005)
      begin
        if (b == 12'h003) ptr[k] = ptr[k] + 12'h001;
        tg = (b == 12'h004) ? ptr[k] + {{4{acc[7]}}, acc} : ptr[k];
        if (b == 12'h001) ptr[k] = ptr[k] + 12'h001;
        if (b == 12'h002) ptr[k] = ptr[k] - 12'h001;
      end
    end
    // a pointer aimed at the flag register makes it the target as well
    ft = mv && d && (tg == dasf_pkg::FLAG_SFR_ADDR);
    w = mv && d && !ft;
    fl = (ft && m == 5'h00) ? r[4:0] : (fl & ~m) | (nf & m);
    if (md != dasf_pkg::M_JMP && !(mv && d)) acc = r;
    #1;
    chk(flag_out === {3'h0, fl}, "flags");
    chk(acc_out === acc, "accumulator");
    chk(mem_valid === mv && (!mv || mem_addr === tg && mem_write === w
        && mem_wdata === r), "memory access");
    chk(jump_valid === (md == dasf_pkg::M_JMP)
        && (md != dasf_pkg::M_JMP || jump_target === p), "jump");
  endtask : ex

  // bounded run: a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    $display("[FAIL] %0t: run timed out", $time);
    n_errors++;
    end_of_test();
  end

  initial
  begin
    {rst, psel, penable, pwrite, exec_valid, exec_access, exec_dest} = 7'h40;
    {paddr, pwdata, exec_operand, exec_file, exec_bit} = '0;
    {exec_full_addr, exec_prog_addr} = '0;
    exec_op = dasf_pkg::OP_ADD;
    exec_mode = dasf_pkg::M_INH;
    {acc, fl, bank, xs, n_errors, total_checks} = '0;
    ptr = '{default: 12'h000};
    rd = $urandom(25);
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    // register access: upper flag bits read zero, unmapped offset refused
    apb(1'b1, dasf_pkg::REG_FLAG, 32'h0000_00ff, rd);
    apb(1'b0, dasf_pkg::REG_FLAG, 32'h0000_0000, rd);
    fl = 5'h1f;
    chk(rd === 32'h0000_001f && sl === 1'b0, "flag readback");
    apb(1'b0, 8'h40, 32'h0000_0000, rd);
    chk(sl === 1'b1 && rd === 32'h0000_0000, "unmapped read");
    apb(1'b1, dasf_pkg::REG_BANK, 32'h0000_0005, rd);
    bank = 4'h5;
    $display("test registers done");
    // random operations across literal and direct modes
    repeat (80)
      ex(dasf_pkg::dasf_op_t'($urandom_range(12)),
         dasf_pkg::dasf_mode_t'($urandom_range(2)),
         8'($urandom), 8'($urandom), 1'($urandom),
         1'($urandom), 20'h00000);
    $display("test random alu done");
    // flag register as destination, full address and jump
    apb(1'b1, dasf_pkg::REG_FLAG, 32'h0000_001b, rd);
    fl = 5'h1b;
    ex(dasf_pkg::OP_CLR, dasf_pkg::M_DIR, 8'h00, 8'hd8, 1'b0, 1'b1,
       20'h00000);
    ex(dasf_pkg::OP_ADD, dasf_pkg::M_DIR, 8'h80, 8'hd8, 1'b0, 1'b1,
       20'h00000);
    ex(dasf_pkg::OP_BSET, dasf_pkg::M_DIR, {3'h0, fl}, 8'hd8, 1'b0, 1'b1,
       20'h00000);
    ex(dasf_pkg::OP_MOVF, dasf_pkg::M_FULL, 8'h3c, 8'h00, 1'b1, 1'b1,
       20'h00abc);
    ex(dasf_pkg::OP_MOVF, dasf_pkg::M_JMP, 8'h00, 8'h00, 1'b0, 1'b0,
       20'h9a5c3);
    $display("test flag target and jump done");
    // every operand kind of every pointer pair, across the low byte wrap
    for (int k = 0; k < 3; k++)
      for (int v = 0; v < 5; v++)
      begin
        ptr[k] = 12'h0ff + 12'(v == 2);
        apb(1'b1, 8'(dasf_pkg::REG_PTR0 + 4 * k), {20'h0, ptr[k]}, rd);
        ex(dasf_pkg::OP_MOVF, dasf_pkg::M_DIR, 8'($urandom),
           8'(dasf_pkg::VIRT_BASE[k] - v), 1'b0, 1'b0,
           20'h00000);
        apb(1'b0, 8'(dasf_pkg::REG_PTR0 + 4 * k), 32'h0, rd);
        chk(rd === {20'h0, ptr[k]}, "pointer step");
      end
    $display("test pointer operands done");
    // extended set: low access offsets index from pair two, others do not
    apb(1'b1, dasf_pkg::REG_CFG, 32'h0000_0001, rd);
    xs = 1'b1;
    ex(dasf_pkg::OP_MOVF, dasf_pkg::M_DIR, 8'h5a, 8'h5f, 1'b0, 1'b1,
       20'h00000);
    ex(dasf_pkg::OP_MOVF, dasf_pkg::M_DIR, 8'h5a, 8'h60, 1'b0, 1'b1,
       20'h00000);
    $display("test indexed offset done");
    end_of_test();
  end
endmodule : data_address_and_status_flags_tb_top
`default_nettype wire
